//--- logic/cpi_pkg.sv
package cpi_pkg;
  // Opcodes of the two interrupt-control instructions.
  localparam logic [11:0] OP_INT_ENABLE = 12'hC01;
  localparam logic [11:0] OP_INT_DISABLE = 12'hC02;
  // Forced subroutine call target and the vector word that follows it.
  localparam logic [11:0] CALL_ADDR = 12'h000;
  localparam logic [11:0] VECTOR_ADDR = 12'h001;
  localparam logic ENABLE_RESET = 1'b0;
  localparam int DEV_COUNT = 8;

  typedef struct packed {
    logic done;
    logic [11:0] opcode;
    logic [11:0] next_pc;
  } cpi_retire_t;

  typedef struct packed {
    logic take;
    logic [11:0] store_addr;
    logic [11:0] store_data;
    logic [11:0] fetch_addr;
  } cpi_force_t;
endpackage

//--- logic/cpi_unit.sv
// How it works
// - Decoding opcode 6001 turns the interrupt facility on.
// - Decoding opcode 6002 turns the interrupt facility off.
// - With facility on and a flag set, interrupt waits for current instruction end.
// - Taking an interrupt stores the next program counter into location 0.
// - After the store, the processor fetches the instruction at location 1.
// - Taking an interrupt turns the facility off.
// - An enable takes effect only after the following instruction completes.
`timescale 1ns/1ps
`default_nettype none
module cpi_unit #(
  parameter int NDEV = cpi_pkg::DEV_COUNT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [NDEV-1:0] dev_ready,
  input wire cpi_pkg::cpi_retire_t retire,
  output cpi_pkg::cpi_force_t force_call,
  output logic int_enabled
);
  // Refused while the design is being built, since a unit with no flags can never interrupt.
  if (NDEV < 1)
  begin : g_ndev_check
    $error("NDEV must be at least one");
  end

  logic enable_r;
  logic enable_nxt;
  logic pending_r;
  logic pending_nxt;
  logic [11:0] ret_pc_r;
  logic take_r;

  // Flags from the same clock domain need no synchroniser.
  wire irq_any = |dev_ready;
  wire is_on = retire.done && (retire.opcode == cpi_pkg::OP_INT_ENABLE);
  wire is_off = retire.done && (retire.opcode == cpi_pkg::OP_INT_DISABLE);
  // An interrupt is only taken at an instruction boundary.
  // The instruction that ends the shadow of an enable is never interrupted, even
  // when the facility was already on, so the return jump always completes.
  wire take = enable_r && irq_any && retire.done && !is_off && !is_on && !pending_r;

  // The pending stage holds off the enable for one more instruction so the
  // return jump that follows it finishes before a new interrupt can fire.
  always_comb
  begin
    enable_nxt = enable_r;
    pending_nxt = pending_r;
    if (retire.done)
    begin
      if (pending_r)
      begin
        enable_nxt = 1'b1;
        pending_nxt = 1'b0;
      end
      if (is_on)
        pending_nxt = 1'b1;
      if (is_off)
      begin
        enable_nxt = 1'b0;
        pending_nxt = 1'b0;
      end
      if (take)
        enable_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      enable_r <= cpi_pkg::ENABLE_RESET;
      pending_r <= 1'b0;
      take_r <= 1'b0;
      ret_pc_r <= 12'h000;
    end
    else
    begin
      enable_r <= enable_nxt;
      pending_r <= pending_nxt;
      take_r <= take;
      if (take)
        ret_pc_r <= retire.next_pc;
    end
  end

  assign force_call.take = take_r;
  assign force_call.store_addr = cpi_pkg::CALL_ADDR;
  assign force_call.store_data = ret_pc_r;
  assign force_call.fetch_addr = cpi_pkg::VECTOR_ADDR;
  assign int_enabled = enable_r;

  property p_on;
    @(posedge sys_clk) disable iff (sys_rst)
    is_on && !enable_r |=> pending_r && !enable_r;
  endproperty
  a_on: assert property (p_on) else $error("enable not delayed");

  property p_off;
    @(posedge sys_clk) disable iff (sys_rst) is_off |=> !enable_r && !pending_r;
  endproperty
  a_off: assert property (p_off) else $error("disable failed");

  property p_boundary;
    @(posedge sys_clk) disable iff (sys_rst) take_r |-> $past(retire.done);
  endproperty
  a_boundary: assert property (p_boundary) else $error("take mid instruction");

  property p_store;
    @(posedge sys_clk) disable iff (sys_rst)
    take |=> force_call.take && force_call.store_data == $past(retire.next_pc);
  endproperty
  a_store: assert property (p_store) else $error("wrong return address");

  property p_fetch;
    @(posedge sys_clk) disable iff (sys_rst)
    force_call.take |-> force_call.fetch_addr == 12'h001 && force_call.store_addr == 12'h000;
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad vector");

  property p_self_off;
    @(posedge sys_clk) disable iff (sys_rst) take |=> !enable_r;
  endproperty
  a_self_off: assert property (p_self_off) else $error("still enabled");

  property p_delay;
    @(posedge sys_clk) disable iff (sys_rst) pending_r |-> !take;
  endproperty
  a_delay: assert property (p_delay) else $error("interrupt in shadow");

  property p_or;
    @(posedge sys_clk) disable iff (sys_rst)
    enable_r && retire.done && !is_on && !is_off && dev_ready != '0 |=> force_call.take;
  endproperty
  a_or: assert property (p_or) else $error("request missed");

  // An enable instruction is itself never interrupted.
  property p_on_no_take;
    @(posedge sys_clk) disable iff (sys_rst)
    is_on |=> !force_call.take;
  endproperty
  a_on_no_take: assert property (p_on_no_take) else $error("enable interrupted");

  // A disable instruction is itself never interrupted.
  property p_off_no_take;
    @(posedge sys_clk) disable iff (sys_rst)
    is_off |=> !force_call.take;
  endproperty
  a_off_no_take: assert property (p_off_no_take) else $error("disable interrupted");

  // The shadow ends with the next completed instruction unless that one disables or enables again.
  property p_shadow_end;
    @(posedge sys_clk) disable iff (sys_rst)
    pending_r && retire.done && !is_off && !is_on |=> enable_r && !pending_r;
  endproperty
  a_shadow_end: assert property (p_shadow_end) else $error("shadow too long");

  // A forced call needs at least one flag up at the boundary before it.
  property p_take_flag;
    @(posedge sys_clk) disable iff (sys_rst)
    force_call.take |-> $past(dev_ready != '0);
  endproperty
  a_take_flag: assert property (p_take_flag) else $error("call without flag");

  // A forced call needs the facility on at the boundary before it.
  property p_take_enabled;
    @(posedge sys_clk) disable iff (sys_rst)
    force_call.take |-> $past(enable_r);
  endproperty
  a_take_enabled: assert property (p_take_enabled) else $error("call while off");

  // The call lasts one cycle because taking it switches the facility off.
  property p_pulse;
    @(posedge sys_clk) disable iff (sys_rst)
    force_call.take |=> !force_call.take;
  endproperty
  a_pulse: assert property (p_pulse) else $error("call longer than one cycle");

  // The saved return address only moves when a new call is made.
  property p_hold_ret;
    @(posedge sys_clk) disable iff (sys_rst)
    !take |=> $stable(force_call.store_data);
  endproperty
  a_hold_ret: assert property (p_hold_ret) else $error("return address moved");

  // The enable state only changes when an instruction completes.
  property p_idle_stable;
    @(posedge sys_clk) disable iff (sys_rst)
    !retire.done |=> $stable(enable_r);
  endproperty
  a_idle_stable: assert property (p_idle_stable) else $error("enable moved idle");

  // While the facility is off no call is requested.
  property p_off_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
    !enable_r |-> !take;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("call while disabled");

  // With every flag low there is nothing to take.
  property p_no_flag;
    @(posedge sys_clk) disable iff (sys_rst)
    dev_ready == '0 |-> !take;
  endproperty
  a_no_flag: assert property (p_no_flag) else $error("call with no flag");

  // Reset leaves the facility off and no call in flight.
  property p_reset_off;
    @(posedge sys_clk)
    sys_rst |=> !enable_r && !force_call.take;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset left facility on");
endmodule
`default_nettype wire

//--- verif/cpi_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpi_dev_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] raise,
  input wire logic clear,
  output logic [7:0] dev_ready
);
  // A flag stays up until service code clears it, so a late clear re-interrupts.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || clear) dev_ready <= 8'h00;
    else dev_ready <= dev_ready | raise;
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end end
module tb_top;
  logic sys_clk = 0, sys_rst = 1, clear = 0, int_enabled;
  logic [7:0] raise = 8'h00, dev_ready;
  logic [11:0] e_v, rpc = 12'h000;
  cpi_pkg::cpi_retire_t retire = '0;
  cpi_pkg::cpi_force_t force_call;
  logic [11:0] exp_q[$];
  int fail_count = 0, checked = 0, cycles = 0, seed = 36269;
  initial forever #5 sys_clk = ~sys_clk;
  cpi_dev_model i_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .raise(raise), .clear(clear),
    .dev_ready(dev_ready));
  cpi_unit i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .dev_ready(dev_ready),
    .retire(retire), .force_call(force_call), .int_enabled(int_enabled));
  task test_done;
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task ret(input logic [11:0] op, input logic [11:0] pc);
    @(posedge sys_clk);
    #1 retire = {1'b1, op, pc};
    @(posedge sys_clk);
    #1 retire.done = 1'b0;
  endtask
  // Any take without a noted expectation compares against an impossible address.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 2000) begin fail_count++; test_done; end
    if (force_call.take === 1'b1)
    begin
      e_v = exp_q.size() ? exp_q.pop_front() : 12'hFFF;
      `CHK("store_data", e_v, force_call.store_data)
      `CHK("addrs", 24'h000001, {force_call.store_addr, force_call.fetch_addr})
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 0;
    `CHK("en_rst", 1'b0, int_enabled)
    raise = 8'(8'h01 << ($random(seed) & 7));
    ret(12'h123, 12'h200);
    raise = 8'h00;
    ret(cpi_pkg::OP_INT_ENABLE, 12'h201);
    `CHK("shadow", 1'b0, int_enabled)
    ret(12'h0A5, 12'h202);
    `CHK("en", 1'b1, int_enabled)
    rpc = 12'($random(seed));
    exp_q.push_back(rpc);
    ret(12'h0B6, rpc);
    `CHK("en_take", 1'b0, int_enabled)
    ret(12'h0B7, 12'h2A8);
    ret(cpi_pkg::OP_INT_ENABLE, 12'h2A9);
    ret(cpi_pkg::OP_INT_DISABLE, 12'h2AA);
    ret(12'h0B8, 12'h2AB);
    `CHK("cancel", 1'b0, int_enabled)
    ret(cpi_pkg::OP_INT_ENABLE, 12'h2AC);
    clear = 1;
    ret(12'h0B9, 12'h2AD);
    clear = 0;
    ret(12'h0BA, 12'h2AE);
    `CHK("no_flag", 1'b1, int_enabled)
    ret(cpi_pkg::OP_INT_DISABLE, 12'h2AF);
    `CHK("dis", 1'b0, int_enabled)
    `CHK("pending", 32'd0, 32'(exp_q.size()))
    test_done;
  end
endmodule
`default_nettype wire
